// *** rtl/xmb_pkg.sv ***
// package: constants and carrier types for the external memory bus interface
package xmb_pkg;

   // ****************************************
   // register fields
   // ****************************************
   localparam int SYS_EN_BIT      = 7;
   localparam int SYS_UWAIT_LO    = 6;
   localparam int EXT_LIMIT_HI    = 6;
   localparam int EXT_LIMIT_LO    = 4;
   localparam int EXT_LWAIT_HI    = 3;
   localparam int EXT_LWAIT_LO    = 2;
   localparam int EXT_UWAIT_HI    = 1;
   localparam logic [7:0] SYS_CTRL_RST = 8'h00;
   localparam logic [7:0] EXT_CTRL_RST = 8'h00;

   // ****************************************
   // memory map and timing
   // ****************************************
   localparam logic [15:0] INT_TOP      = 16'h0260;
   localparam int          SECTOR_SHIFT = 13;
   localparam logic [1:0]  STRB_BASE    = 2'h2;
   localparam logic [1:0]  WAIT_NONE    = 2'h0;
   localparam logic [1:0]  WAIT_ONE     = 2'h1;
   localparam logic [1:0]  WAIT_TWO     = 2'h2;
   localparam logic [1:0]  WAIT_TWO_REC = 2'h3;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic        we;
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        next_ram;
   } xmb_req_t;

   typedef struct packed {
      logic [7:0] low_out;
      logic [7:0] low_dir;
      logic [7:0] high_out;
      logic [7:0] high_dir;
      logic [3:0] ctl_out;
      logic [3:0] ctl_dir;
   } xmb_port_t;

endpackage

// *** rtl/xmb_sync2.sv ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module xmb_sync2 import xmb_pkg::*; #(
   parameter int W = 8
) (
   input  wire logic         core_clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta <= '0;
         dout <= '0;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule // xmb_sync2

// *** rtl/xmb_wait_dec.sv ***
// sector select and wait-state decode for one external access
`timescale 1ns/1ps
module xmb_wait_dec import xmb_pkg::*; (
   input  wire logic [15:0] addr,
   input  wire logic [7:0]  sys_ctrl,
   input  wire logic [7:0]  ext_ctrl,
   output logic      [1:0]  wait_cnt,
   output logic             recover,
   output logic             lower_hit
);
   wire [2:0]  limit;
   wire [15:0] bound;
   wire [1:0]  upper_sel;
   wire [1:0]  lower_sel;
   wire [1:0]  sel;

   assign limit     = ext_ctrl[EXT_LIMIT_HI:EXT_LIMIT_LO];
   assign bound     = {limit, 13'h0000};
   // zero limit: whole space is the upper sector
   assign lower_hit = (limit != 3'h0) && (addr < bound);
   assign upper_sel = {ext_ctrl[EXT_UWAIT_HI], sys_ctrl[SYS_UWAIT_LO]};
   assign lower_sel = {ext_ctrl[EXT_LWAIT_HI], ext_ctrl[EXT_LWAIT_LO]};
   assign sel       = lower_hit ? lower_sel : upper_sel;
   assign wait_cnt  = (sel == WAIT_TWO_REC) ? WAIT_TWO : sel;
   assign recover   = (sel == WAIT_TWO_REC);
endmodule // xmb_wait_dec

// *** rtl/xmb_ctrl.sv ***
// external memory bus interface: control registers, cycle sequencer, pins
//
// Notes on behaviour
// - low address/data bus, high address, strobes
// - only external accesses run full bus cycles
// - address valid on low bus when external address-phase latch falls
// - latch strobe low during data transfer
// - internal access never moves read/write strobes
// - disabled: no aliasing, pins back to port
// - pull-ups follow port output register bits
// - keeper holds last driven low bus value
// - four software wait-state settings
// - two sectors, each own wait setting
// - final-period latch pulse only if next RAM
// - enable bit 7 takes over pins
// - upper wait bits at sys 6, ext 1
// - limit in ext 6..4, lower wait 3..2
// - zero limit: single upper sector
// - lower sector below k times 0x2000
// - wait encoding including recovery cycle
// - lower pair times lower sector accesses
`timescale 1ns/1ps
module xmb_ctrl import xmb_pkg::*; #(
   parameter int HI_BITS = 8
) (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       sys_wr,
   input  wire logic       ext_wr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] sys_ctrl,
   output logic      [7:0] ext_ctrl,
   input  wire logic       keeper_en,
   input  xmb_port_t       port_cfg,
   input  wire logic       core_req,
   input  xmb_req_t        core_cmd,
   output logic            core_ready,
   output logic            core_done,
   output logic            core_ext,
   output logic      [7:0] core_rdata,
   input  wire logic [7:0] ad_i,
   output logic      [7:0] ad_o,
   output logic      [7:0] ad_oe,
   output logic      [7:0] ad_pullup,
   output logic            ad_keep,
   output logic      [7:0] ad_keep_val,
   output logic      [7:0] addr_high_o,
   output logic      [7:0] addr_high_oe,
   output logic            ale_o,
   output logic            ale_oe,
   output logic            rd_n_o,
   output logic            rd_n_oe,
   output logic            wr_n_o,
   output logic            wr_n_oe
);

   // ****************************************
   // types and state
   // ****************************************
   typedef enum logic [2:0] {
      ST_IDLE, ST_INT, ST_ADDR, ST_LATCH,
      ST_STRB, ST_FINAL, ST_RECOV
   } xmb_state_t;

   xmb_state_t state;
   xmb_state_t next_state;
   xmb_req_t   cmd;
   logic [2:0] cnt;
   logic [2:0] next_cnt;
   logic       rec;
   logic [7:0] ad_sync;
   logic [1:0] wait_cnt;
   logic       recover;

   // ****************************************
   // control registers
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sys_ctrl <= SYS_CTRL_RST;
         ext_ctrl <= EXT_CTRL_RST;
      end else begin
         if (sys_wr) begin
            sys_ctrl <= reg_wdata;
         end
         if (ext_wr) begin
            ext_ctrl <= reg_wdata;
         end
      end
   end

   wire en = sys_ctrl[SYS_EN_BIT];

   // ****************************************
   // access decode
   // ****************************************
   wire take     = core_req && (state == ST_IDLE);
   wire above    = core_cmd.addr >= INT_TOP;
   wire go_ext   = take && en && above;
   wire go_int   = take && en && !above;
   // disabled: nothing is mapped, at any address
   wire go_none  = take && !en;

   assign core_ready = (state == ST_IDLE);

   xmb_wait_dec u_dec (
      .addr      (cmd.addr),
      .sys_ctrl  (sys_ctrl),
      .ext_ctrl  (ext_ctrl),
      .wait_cnt  (wait_cnt),
      .recover   (recover),
      .lower_hit ()
   );

   xmb_sync2 #(.W(8)) u_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .din      (ad_i),
      .dout     (ad_sync)
   );

   // ****************************************
   // sequencer
   // ****************************************
   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      case (state)
         ST_IDLE: begin
            if (go_ext) begin
               next_state = ST_ADDR;
            end else if (go_int) begin
               next_state = ST_INT;
            end
         end
         ST_INT: begin
            next_state = ST_IDLE;
         end
         ST_ADDR: begin
            next_state = ST_LATCH;
         end
         ST_LATCH: begin
            next_state = ST_STRB;
            // three bits: base plus two waits does not fit in two
            next_cnt   = 3'(STRB_BASE) + 3'(wait_cnt);
         end
         ST_STRB: begin
            if (cnt == 3'h0) begin
               next_state = ST_FINAL;
            end else begin
               next_cnt = cnt - 3'h1;
            end
         end
         ST_FINAL: begin
            next_state = rec ? ST_RECOV : ST_IDLE;
         end
         ST_RECOV: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state <= ST_IDLE;
         cnt   <= 3'h0;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
      end
   end

   // ****************************************
   // request capture and answer
   // ****************************************
   wire strb_end = (state == ST_STRB) && (cnt == 3'h0);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cmd        <= '0;
         rec        <= 1'b0;
         core_done  <= 1'b0;
         core_ext   <= 1'b0;
         core_rdata <= 8'h00;
      end else begin
         if (take) begin
            cmd      <= core_cmd;
            core_ext <= go_ext;
         end
         if (state == ST_LATCH) begin
            rec <= recover;
         end
         if (strb_end && !cmd.we) begin
            core_rdata <= ad_sync;
         end else if (go_none) begin
            core_rdata <= 8'h00;
         end
         core_done <= strb_end || go_none || (state == ST_INT);
      end
   end

   // ****************************************
   // pin drive
   // ****************************************
   wire in_strb  = (state == ST_STRB);
   wire fin      = (state == ST_FINAL);
   wire addr_ph  = (state == ST_ADDR) || (state == ST_LATCH)
                || (state == ST_INT);
   wire wr_data  = cmd.we && (in_strb || fin);
   wire bus_ad   = addr_ph || wr_data;

   // latch strobe: address phase or the optional final pulse
   wire ale_x    = (state == ST_ADDR) || (state == ST_INT)
                || (fin && cmd.next_ram);
   wire rd_x_n   = !(in_strb && !cmd.we);
   wire wr_x_n   = !(in_strb && cmd.we);

   wire [7:0] ad_x = addr_ph ? cmd.addr[7:0] : cmd.wdata;

   // high bits above HI_BITS stay with the port
   wire [7:0] hi_own = 8'(((16'h0001 << HI_BITS) - 16'h0001));

   assign ad_o = en ? ad_x : port_cfg.low_out;
   assign ad_oe = en ? {8{bus_ad}} : port_cfg.low_dir;
   assign addr_high_o  = en ? ((cmd.addr[15:8] & hi_own)
                             | (port_cfg.high_out & ~hi_own))
                            : port_cfg.high_out;
   assign addr_high_oe = en ? (hi_own | port_cfg.high_dir)
                            : port_cfg.high_dir;
   assign ale_o   = en ? ale_x  : port_cfg.ctl_out[2];
   assign ale_oe  = en ? 1'b1   : port_cfg.ctl_dir[2];
   assign rd_n_o  = en ? rd_x_n : port_cfg.ctl_out[1];
   assign rd_n_oe = en ? 1'b1   : port_cfg.ctl_dir[1];
   assign wr_n_o  = en ? wr_x_n : port_cfg.ctl_out[0];
   assign wr_n_oe = en ? 1'b1   : port_cfg.ctl_dir[0];

   // ****************************************
   // pull-ups and bus keeper
   // ****************************************
   assign ad_pullup = port_cfg.low_out & ~ad_oe;
   assign ad_keep   = keeper_en;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ad_keep_val <= 8'h00;
      end else begin
         ad_keep_val <= (ad_o & ad_oe) | (ad_keep_val & ~ad_oe);
      end
   end

   // ****************************************
   // checks
   // ****************************************
   sequence s_addr_latch;
      (state == ST_ADDR) && ale_o ##1 !ale_o && (ad_o == cmd.addr[7:0]);
   endsequence

   sequence s_ext_start;
      en && go_ext;
   endsequence

   chk_addr_at_fall: assert property (@(posedge core_clk) disable iff (rst)
      s_ext_start |=> s_addr_latch)
      else $error("address not on low bus when latch falls");

   chk_ale_low_data: assert property (@(posedge core_clk) disable iff (rst)
      (en && (!rd_n_o || !wr_n_o)) |-> !ale_o)
      else $error("latch strobe high during data transfer");

   chk_int_no_strb: assert property (@(posedge core_clk) disable iff (rst)
      go_int |=> (rd_n_o && wr_n_o) [*2])
      else $error("strobe moved on internal access");

   chk_strobe_excl: assert property (@(posedge core_clk) disable iff (rst)
      en |-> (rd_n_o || wr_n_o))
      else $error("both strobes asserted");

   chk_disabled_pins: assert property (@(posedge core_clk) disable iff (rst)
      !en |-> (ad_oe == port_cfg.low_dir) && (rd_n_o == port_cfg.ctl_out[1]))
      else $error("pins not returned to port use");

   chk_none_done: assert property (@(posedge core_clk) disable iff (rst)
      go_none |=> core_done && !core_ext && (core_rdata == 8'h00))
      else $error("unmapped access not answered");

   chk_no_wait_len: assert property (@(posedge core_clk) disable iff (rst)
      ((state == ST_LATCH) && (wait_cnt == WAIT_NONE))
      |=> !(rd_n_o && wr_n_o) [*3] ##1 (state == ST_FINAL))
      else $error("strobe length wrong for no-wait setting");

   chk_two_wait_len: assert property (@(posedge core_clk) disable iff (rst)
      ((state == ST_LATCH) && (wait_cnt == WAIT_TWO))
      |=> (state == ST_STRB) [*5] ##1 (state == ST_FINAL))
      else $error("strobe length wrong for two-wait setting");

   chk_recovery: assert property (@(posedge core_clk) disable iff (rst)
      ((state == ST_FINAL) && rec) |=> (state == ST_RECOV) && (ad_oe == 8'h00))
      else $error("missing recovery cycle");

   chk_zero_limit: assert property (@(posedge core_clk) disable iff (rst)
      ((ext_ctrl[EXT_LIMIT_HI:EXT_LIMIT_LO] == 3'h0)
       && ({ext_ctrl[EXT_UWAIT_HI], sys_ctrl[SYS_UWAIT_LO]} == WAIT_TWO_REC))
      |-> recover)
      else $error("zero limit not using upper wait bits");

   chk_lower_sector: assert property (@(posedge core_clk) disable iff (rst)
      ((ext_ctrl[EXT_LIMIT_HI:EXT_LIMIT_LO] != 3'h0)
       && (cmd.addr < {ext_ctrl[EXT_LIMIT_HI:EXT_LIMIT_LO], 13'h0000}))
      |-> (recover == (ext_ctrl[EXT_LWAIT_HI:EXT_LWAIT_LO] == WAIT_TWO_REC)))
      else $error("lower sector wait bits not applied");

   chk_final_ale: assert property (@(posedge core_clk) disable iff (rst)
      (state == ST_FINAL) |-> (ale_o == cmd.next_ram))
      else $error("final latch pulse wrong");

   chk_pullup: assert property (@(posedge core_clk) disable iff (rst)
      (ad_oe == 8'h00) |-> (ad_pullup == port_cfg.low_out))
      else $error("pull-up not following port register");

   chk_keeper: assert property (@(posedge core_clk) disable iff (rst)
      (ad_oe == 8'hff) ##1 (ad_oe == 8'h00) |-> (ad_keep_val == $past(ad_o)))
      else $error("keeper lost last driven value");

   chk_ext_flag: assert property (@(posedge core_clk) disable iff (rst)
      go_ext |=> core_ext && (state == ST_ADDR))
      else $error("external access not flagged");

endmodule // xmb_ctrl

// *** dv/xmb_sram_model.sv ***
// partner model: transparent address latch plus asynchronous byte memory
`timescale 1ns/1ps
module xmb_sram_model import xmb_pkg::*; #(
   parameter int RD_DLY = 3
) (
   input  wire logic [7:0] bus,
   input  wire logic [7:0] addr_high,
   input  wire logic       ale,
   input  wire logic       rd_n,
   input  wire logic       wr_n,
   output logic            drv_en,
   output logic      [7:0] drv_val
);
   logic [7:0]  lat;
   logic [15:0] acc_addr;
   logic [7:0]  rdv;
   logic [7:0]  mem [int];

   // passes while the strobe is high, holds once it is low
   always_latch begin
      if (ale) begin
         lat <= bus;
      end
   end

   // no clock here: only strobe edges are trusted
   always @(negedge rd_n or negedge wr_n) begin
      acc_addr = {addr_high, lat};
      rdv = mem.exists(int'(acc_addr)) ? mem[int'(acc_addr)] : 8'h00;
   end

   always @(posedge wr_n) begin
      mem[int'(acc_addr)] = bus;
   end

   assign #RD_DLY drv_en = (rd_n === 1'b0);
   assign drv_val = rdv;
endmodule // xmb_sram_model

// *** dv/xmb_ctrl_bench.sv ***
// self-checking bench for the external memory bus controller
`timescale 1ns/1ps
module xmb_ctrl_bench;
   import xmb_pkg::*;
   logic       core_clk, rst, sys_wr, ext_wr, keeper_en, core_req;
   logic [7:0] reg_wdata, sys_ctrl, ext_ctrl, core_rdata, last_ad;
   xmb_port_t  port_cfg;
   xmb_req_t   core_cmd;
   logic       core_ready, core_done, core_ext, ad_keep, ale_o, ale_oe;
   logic       rd_n_o, rd_n_oe, wr_n_o, wr_n_oe, m_en;
   logic [7:0] ad_o, ad_oe, ad_pullup, ad_keep_val, addr_high_o, addr_high_oe, m_val;
   wire logic [7:0] bus;
   int         num_errors, total_checks, cyc, rd_lo, wr_lo, ale_hi;

   // undriven lines: keeper value, else pull-up, else a changing pattern
   assign bus = (ad_o & ad_oe) | (m_val & ~ad_oe & {8{m_en}})
              | ((ad_keep ? ad_keep_val : (ad_pullup | ~last_ad)) & ~ad_oe & ~{8{m_en}});

   xmb_ctrl DUT (.core_clk(core_clk), .rst(rst), .sys_wr(sys_wr), .ext_wr(ext_wr),
      .reg_wdata(reg_wdata), .sys_ctrl(sys_ctrl), .ext_ctrl(ext_ctrl), .keeper_en(keeper_en),
      .port_cfg(port_cfg), .core_req(core_req), .core_cmd(core_cmd), .core_ready(core_ready),
      .core_done(core_done), .core_ext(core_ext), .core_rdata(core_rdata), .ad_i(bus),
      .ad_o(ad_o), .ad_oe(ad_oe), .ad_pullup(ad_pullup), .ad_keep(ad_keep),
      .ad_keep_val(ad_keep_val), .addr_high_o(addr_high_o), .addr_high_oe(addr_high_oe),
      .ale_o(ale_o), .ale_oe(ale_oe), .rd_n_o(rd_n_o), .rd_n_oe(rd_n_oe), .wr_n_o(wr_n_o),
      .wr_n_oe(wr_n_oe));

   xmb_sram_model #(.RD_DLY(3)) mem_i (.bus(bus), .addr_high(addr_high_o), .ale(ale_o),
      .rd_n(rd_n_o), .wr_n(wr_n_o), .drv_en(m_en), .drv_val(m_val));

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // ****************************************
   // monitors and helpers
   // ****************************************
   always @(posedge core_clk) begin
      last_ad <= bus;
      cyc++;
      if (!rd_n_o) rd_lo++;
      if (!wr_n_o) wr_lo++;
      if (ale_o) ale_hi++;
      if (!rd_n_o && !wr_n_o) chk("strobe overlap", 16'h0, 16'h1);
      if ((!rd_n_o || !wr_n_o) && ale_o) chk("latch in data phase", 16'h0, 16'h1);
      if (cyc == 20000) begin
         num_errors++;
         end_of_test();
      end
   end

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wreg(input logic ext, input logic [7:0] v);
      reg_wdata = v;
      sys_wr = !ext;
      ext_wr = ext;
      @(posedge core_clk);
      #1 sys_wr = 1'b0;
      ext_wr = 1'b0;
      chk("register", v, ext ? ext_ctrl : sys_ctrl);
      @(posedge core_clk) #1;
   endtask

   // one core access; lat counts cycles after the taking edge
   task automatic acc(input logic we, input logic [15:0] a, input logic [7:0] d,
                      input logic nr, input int lat, input int strb);
      int i;
      while (core_ready !== 1'b1) @(posedge core_clk) #1;
      core_cmd = '{we: we, addr: a, wdata: d, next_ram: nr};
      core_req = 1'b1;
      rd_lo = 0;
      wr_lo = 0;
      ale_hi = 0;
      @(posedge core_clk);
      #1 core_req = 1'b0;
      i = 0;
      do begin
         @(negedge core_clk);
         i++;
      end while (core_done !== 1'b1 && i < 40);
      @(posedge core_clk);
      #1 chk("latency", lat, i);
      chk("strobe cycles", strb, we ? wr_lo : rd_lo);
      chk("other strobe", 0, we ? rd_lo : wr_lo);
      chk("latch pulses", (lat > 1) ? 1 + nr : 0, ale_hi);
      chk("external flag", 16'(lat > 2), core_ext);
      if (!we) chk("read data", d, core_rdata);
   endtask

   task automatic end_of_test();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      logic [1:0] w;
      int         x;
      rst = 1'b1; sys_wr = 1'b0; ext_wr = 1'b0; reg_wdata = 8'h00; keeper_en = 1'b0;
      core_req = 1'b0; core_cmd = '0; last_ad = 8'h00; cyc = 0;
      num_errors = 0; total_checks = 0;
      port_cfg = '{low_out: 8'ha5, low_dir: 8'h0f, high_out: 8'h00, high_dir: 8'hff,
                   ctl_out: 4'h3, ctl_dir: 4'hf};
      repeat (8) @(posedge core_clk);
      #1 rst = 1'b0;
      chk("sys reset", SYS_CTRL_RST, sys_ctrl);
      chk("ext reset", EXT_CTRL_RST, ext_ctrl);
      chk("port dir", 8'h0f, ad_oe);
      chk("pull-ups", 8'ha0, ad_pullup);
      acc(1'b0, 16'h3000, 8'h00, 1'b0, 1, 0);
      keeper_en = 1'b1;
      wreg(1'b0, 8'h80);
      chk("high dir", 8'hff, addr_high_oe);
      chk("strobe drive", 1'b1, rd_n_oe & wr_n_oe & ale_oe);
      acc(1'b1, 16'h0100, 8'h11, 1'b0, 2, 0);
      acc(1'b0, 16'h0100, 8'h00, 1'b0, 2, 0);
      for (int u = 0; u < 4; u++) begin
         w = u[1:0];
         x = (w == 2'h0) ? 0 : (w == 2'h1) ? 1 : 2;
         wreg(1'b0, {1'b1, w[0], 6'h00});
         wreg(1'b1, {4'h0, 2'h0, w[1], 1'b0});
         acc(1'b1, 16'h0260 + 16'(u) * 16'h1111, 8'h5a ^ 8'(u), w[0], 6 + x, 3 + x);
         chk("keeper value", 8'h5a ^ 8'(u), ad_keep_val);
         acc(1'b0, 16'h0260 + 16'(u) * 16'h1111, 8'h5a ^ 8'(u), w[1], 6 + x, 3 + x);
      end
      chk("keeper enable", 1'b1, ad_keep);
      wreg(1'b0, 8'h80);
      for (int k = 1; k < 8; k++) begin
         wreg(1'b1, {1'b0, 3'(k), 2'h2, 1'b0, 1'b0});
         acc(1'b1, 16'(k) * 16'h2000 - 16'h1, 8'h33, 1'b0, 8, 5);
         acc(1'b1, 16'(k) * 16'h2000, 8'h44, 1'b0, 6, 3);
      end
      wreg(1'b0, 8'h00);
      chk("port dir back", 8'h0f, ad_oe);
      acc(1'b0, 16'h0300, 8'h00, 1'b0, 1, 0);
      end_of_test();
   end
endmodule // xmb_ctrl_bench
